// [hdl/cmd_slave.sv]
// Purpose: byte-level command interpreter of the rectifier management port
// Assumes: front end delivers start/stop/byte strobes and asks for read bytes
// Notes:   acknowledge decision is combinational from the byte in flight
// ----------------------------------------------------------------------------
// Behaviour
// - broadcast writes accepted by every supply
// - reads never answered on broadcast address
// - selector function ignores broadcast transactions
// - alert asserted on first state change
// - address bit zero selects write or read; while cmd holds 00 a read address is taken as a write
// - strap bits form address bits three to one
// - same strap bits for all functions
// - frame: address, command, data, error byte
// - multi-byte values least significant byte first
// - error byte covers address, command, data; reads restart it at the repeated start, without write address and command; code leaves read data out of it
// - values carried in direct format
// - set-point scale 400, no offset
// - fixed scale factors for read quantities
// - output on at power-up if enable low
// - on/off command: 80 on, 00 off
// - restart clears latched alarms and shutdowns
// - clear-faults clears isolation, restart, invalid flags
// - error byte is crc-8 x8+x2+x+1
// - no execution without trailing error byte
// - alert released on status read, clear, recycle; recycle asserts it, and a clear resetting a flag re-asserts it next cycle
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module cmd_slave (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        frame_start,
  input  wire logic        frame_stop,
  input  wire logic        byte_stb,
  input  wire logic [7:0]  byte_in,
  input  wire logic        read_req,
  output logic             ack,
  output logic             selector_ack,
  output logic             memory_ack,
  output logic [7:0]       read_byte,
  input  wire logic        address_strap_bit_2,
  input  wire logic        address_strap_bit_1,
  input  wire logic        address_strap_bit_0,
  input  wire logic        enable_pin_n,
  input  wire logic [7:0]  alarm_in,
  input  wire logic [7:0]  iout_real,
  input  wire logic [7:0]  temp_real,
  input  wire logic [7:0]  vin_real,
  input  wire logic [7:0]  rpm_real,
  output logic             alert_n,
  output logic             output_on,
  output logic [15:0]      vout_code,
  output logic [15:0]      ov_limit_code,
  output logic             led_test,
  output logic             service_led,
  output logic             mem_write_en,
  output logic             auto_restart,
  output logic             iso_test_req,
  output logic             fan_override,
  output logic [7:0]       fan_percent,
  output logic             forced_clock_hold_test
);
  import cmd_slave_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------------
  logic [3:0] pins;
  logic [2:0] strap;
  logic       enable_n;
  pin_sync3 #(.width(4)) u_sync (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .pin_in ({enable_pin_n, address_strap_bit_2, address_strap_bit_1, address_strap_bit_0}),
    .level  (pins)
  );
  assign strap    = pins[2:0];
  assign enable_n = pins[3];

  // ------------------------------------------------------------------
  // frame tracking
  // ------------------------------------------------------------------
  frame_state_t state;
  logic [7:0]   addr_byte;
  logic [7:0]   cmd;
  logic [7:0]   data [0:3];
  logic [2:0]   nbytes;
  logic [7:0]   last_crc;
  logic [7:0]   crc;
  logic         is_read;
  logic [3:0]   rd_idx;
  logic         addr_match;
  logic         addr_bcast;
  logic         first_byte;

  assign first_byte = byte_stb && (state == st_idle);
  // straps feed all three functions alike, so a mis-strap moves them together
  assign addr_match = (byte_in[7:4] == ctrl_nibble) && (byte_in[3:1] == strap);
  assign addr_bcast = (byte_in[7:1] == broadcast_addr) && !byte_in[0];

  always_comb begin
    ack = 1'b0;
    if (first_byte) begin
      ack = addr_match || addr_bcast;
    end else if (byte_stb && (state == st_cmd || state == st_data)) begin
      ack = 1'b1;
    end
  end
  // selector and memory never answer the broadcast pattern
  assign selector_ack = first_byte && (byte_in[7:4] == selector_nibble)
                        && (byte_in[3:1] == strap);
  assign memory_ack   = first_byte && (byte_in[7:4] == memory_nibble)
                        && (byte_in[3:1] == strap);

  pec_crc8 u_crc (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .clear    (frame_start),
    .byte_stb (byte_stb),
    .byte_in  (byte_in),
    .crc      (crc)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= st_idle;
      addr_byte <= 8'h00;
      cmd       <= 8'h00;
      nbytes    <= 3'd0;
      is_read   <= 1'b0;
      last_crc  <= 8'h00;
    end else if (frame_start && state != st_idle && state != st_skip) begin
      // repeated start: a read follows the command
      state <= st_idle;
    end else if (frame_stop) begin
      state  <= st_idle;
      nbytes <= 3'd0;
    end else if (byte_stb) begin
      unique case (state)
        st_idle: begin
          addr_byte <= byte_in;
          if (addr_match || addr_bcast) begin
            if (byte_in[0] && addr_match && cmd != 8'h00) begin
              is_read <= 1'b1;
              state   <= st_read;
            end else begin
              is_read <= 1'b0;
              nbytes  <= 3'd0;
              state   <= st_cmd;
            end
          end else begin
            state <= st_skip;
          end
        end
        st_cmd: begin
          cmd      <= byte_in;
          last_crc <= crc;
          state    <= st_data;
        end
        st_data: begin
          if (nbytes < 3'd4) begin
            nbytes <= nbytes + 3'd1;
          end
          last_crc <= crc;
        end
        st_read, st_skip: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (byte_stb && state == st_data && nbytes < 3'd4) begin
      data[nbytes[1:0]] <= byte_in;
    end
  end

  // ------------------------------------------------------------------
  // write execution at stop
  // ------------------------------------------------------------------
  // the last byte before stop is the error byte, so data = nbytes-1
  logic       wr_done;
  logic       pec_ok;
  logic [2:0] ndata;
  logic       known;
  logic       len_ok;
  assign wr_done = frame_stop && state == st_data && !is_read;
  assign ndata   = (nbytes == 3'd0) ? 3'd0 : nbytes - 3'd1;
  // with no data the frame lacks the error byte entirely
  assign pec_ok  = (nbytes != 3'd0) && (data[ndata[1:0]] == last_crc);

  always_comb begin
    known  = 1'b1;
    len_ok = 1'b0;
    unique case (cmd)
      cmd_operation:                    len_ok = (ndata == 3'd1);
      cmd_vout_set, cmd_ov_limit:       len_ok = (ndata == 3'd2);
      cmd_fan_set:                      len_ok = (ndata == 3'd3);
      cmd_clear_faults, cmd_read_status: len_ok = (ndata == 3'd0);
      default: begin
        known  = (cmd >= cmd_mfr_first) && (cmd <= cmd_mfr_last);
        len_ok = 1'b1;
      end
    endcase
  end

  logic exec;
  logic invalid_evt;
  logic pec_evt;
  assign exec        = wr_done && pec_ok && known && len_ok;
  assign pec_evt     = wr_done && (nbytes != 3'd0) && !pec_ok;
  assign invalid_evt = wr_done && pec_ok && !(known && len_ok);

  // ------------------------------------------------------------------
  // output control
  // ------------------------------------------------------------------
  logic op_cmd_on;
  logic power_init;
  logic on_now;
  logic restart_evt;
  logic prev_on;
  assign on_now = op_cmd_on && !enable_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_cmd_on  <= 1'b1;
      power_init <= 1'b0;
    end else begin
      power_init <= 1'b1;
      if (exec && cmd == cmd_operation) begin
        if (data[0] == op_on) begin
          op_cmd_on <= 1'b1;
        end else if (data[0] == op_off) begin
          op_cmd_on <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_on   <= 1'b0;
      output_on <= 1'b0;
    end else begin
      prev_on   <= on_now;
      output_on <= on_now && power_init;
    end
  end
  // off then on, by command or pin, is a restart
  assign restart_evt = power_init && on_now && !prev_on;

  // ------------------------------------------------------------------
  // settings from write commands
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vout_code              <= vout_reset;
      ov_limit_code          <= vout_reset;
      led_test               <= 1'b0;
      service_led            <= 1'b0;
      mem_write_en           <= 1'b0;
      auto_restart           <= 1'b1;
      iso_test_req           <= 1'b0;
      fan_override           <= 1'b0;
      fan_percent            <= 8'h00;
      forced_clock_hold_test <= 1'b0;
    end else begin
      iso_test_req           <= 1'b0;
      forced_clock_hold_test <= 1'b0;
      if (exec) begin
        unique case (cmd)
          // code is m*volts with m=400, b=0, R=0; stored as sent
          cmd_vout_set:     vout_code     <= {data[1], data[0]};
          cmd_ov_limit:     ov_limit_code <= {data[1], data[0]};
          cmd_led_test_on:  led_test      <= 1'b1;
          cmd_led_test_off: led_test      <= 1'b0;
          cmd_svc_led_on:   service_led   <= 1'b1;
          cmd_svc_led_off:  service_led   <= 1'b0;
          cmd_write_en:     mem_write_en  <= 1'b1;
          cmd_write_dis:    mem_write_en  <= 1'b0;
          cmd_inhibit_rst:  auto_restart  <= 1'b0;
          cmd_auto_rst:     auto_restart  <= 1'b1;
          cmd_iso_test:     iso_test_req  <= 1'b1;
          cmd_fan_set: begin
            fan_override <= 1'b1;
            fan_percent  <= data[0];
          end
          cmd_fan_normal:   fan_override  <= 1'b0;
          cmd_clock_hold:   forced_clock_hold_test <= 1'b1;
          default: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // status flags: a set in the clearing cycle wins
  // ------------------------------------------------------------------
  logic clear_evt;
  logic iso_ok;
  logic iso_fail;
  logic rst_ok;
  logic invalid_flag;
  logic pec_flag;
  logic [7:0] alarm_latch;
  assign clear_evt = exec && cmd == cmd_clear_faults;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      invalid_flag <= 1'b0;
      pec_flag     <= 1'b0;
      rst_ok       <= 1'b0;
      iso_ok       <= 1'b0;
      iso_fail     <= 1'b0;
      alarm_latch  <= 8'h00;
    end else begin
      if (clear_evt || restart_evt) begin
        invalid_flag <= 1'b0;
        pec_flag     <= 1'b0;
        rst_ok       <= 1'b0;
        iso_ok       <= 1'b0;
        iso_fail     <= 1'b0;
        alarm_latch  <= alarm_in;
      end else begin
        alarm_latch  <= alarm_latch | alarm_in;
      end
      if (invalid_evt) invalid_flag <= 1'b1;
      if (pec_evt)     pec_flag     <= 1'b1;
      if (restart_evt) rst_ok       <= 1'b1;
    end
  end

  logic [7:0] status2;
  logic [7:0] status1;
  always_comb begin
    status2 = 8'h00;
    status2[st2_pec_err]  = pec_flag;
    status2[st2_invalid]  = invalid_flag;
    status2[st2_iso_fail] = iso_fail;
    status2[st2_rst_ok]   = rst_ok;
    status2[st2_enable]   = enable_n;
    status1 = 8'h00;
    status1[st1_iso_ok]   = iso_ok;
    status1[st1_shutdown] = !on_now;
    status1[st1_svc_led]  = service_led;
    status1[st1_leds]     = led_test;
    status1[st1_out_on]   = output_on;
  end

  // ------------------------------------------------------------------
  // alert: any change of status2, status1 or the any-alarm summary, no settling wait
  // ------------------------------------------------------------------
  logic [15:0] watched;
  logic [15:0] prev_watched;
  logic        status_read_done;
  assign watched = {status2, status1[6:0], |alarm_latch};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_watched <= 16'h0000;
      alert_n      <= 1'b1;
    end else begin
      prev_watched <= watched;
      if (power_init && watched != prev_watched) begin
        alert_n <= 1'b0;
      end else if (status_read_done || clear_evt || restart_evt) begin
        alert_n <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // read side: block length (status and 0xE1 reads only), data bytes, then error byte
  // ------------------------------------------------------------------
  logic [15:0] iout_code;
  logic [15:0] vin_code;
  logic [15:0] rpm_code;
  assign iout_code = 16'(iout_m * int'(iout_real));
  assign vin_code  = 16'(vin_m * int'(vin_real) + vin_b);
  assign rpm_code  = 16'(rpm_m * int'(rpm_real));

  logic [7:0] next_read_byte;
  logic [3:0] rd_len;
  always_comb begin
    next_read_byte = 8'h00;
    rd_len         = 4'h0;
    unique case (cmd)
      cmd_read_status: begin
        rd_len = status_len;
        unique case (rd_idx)
          4'h0: next_read_byte = {4'h0, status_len};
          4'h1: next_read_byte = status2;
          4'h2: next_read_byte = status1;
          4'h3: next_read_byte = alarm_latch;
          4'h4: next_read_byte = alarm_in;
          4'h5: next_read_byte = vout_code[7:0];
          4'h6: next_read_byte = vout_code[15:8];
          4'h7: next_read_byte = iout_code[7:0];
          4'h8: next_read_byte = iout_code[15:8];
          4'h9: next_read_byte = temp_real;
          4'hA: next_read_byte = 8'h00;
          default: next_read_byte = crc;
        endcase
      end
      cmd_vout_set: begin
        rd_len = 4'h2;
        next_read_byte = (rd_idx == 4'h0) ? vout_code[7:0]
                       : (rd_idx == 4'h1) ? vout_code[15:8] : crc;
      end
      8'hDC: begin
        rd_len = 4'h2;
        next_read_byte = (rd_idx == 4'h0) ? vin_code[7:0]
                       : (rd_idx == 4'h1) ? vin_code[15:8] : crc;
      end
      8'hE1: begin
        rd_len = 4'h4;
        unique case (rd_idx)
          4'h0: next_read_byte = 8'h04;
          4'h1: next_read_byte = fan_percent;
          4'h2: next_read_byte = rpm_code[7:0];
          4'h3: next_read_byte = rpm_code[15:8];
          4'h4: next_read_byte = 8'h00;
          default: next_read_byte = crc;
        endcase
      end
      default: next_read_byte = crc;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_idx           <= 4'h0;
      read_byte        <= 8'h00;
      status_read_done <= 1'b0;
    end else begin
      status_read_done <= 1'b0;
      if (state != st_read) begin
        rd_idx <= 4'h0;
      end else if (read_req) begin
        read_byte <= next_read_byte;
        rd_idx    <= rd_idx + 4'h1;
      end
      if (frame_stop && state == st_read && cmd == cmd_read_status
          && rd_idx > rd_len) begin
        status_read_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/cmd_slave_pkg.sv]
// Purpose: shared constants for the management-port command slave
// Assumes: byte-level serial front end outside this design
// Notes:   direct-format scale factors and command codes live here
package cmd_slave_pkg;
  localparam logic [3:0] ctrl_nibble      = 4'h8;
  localparam logic [3:0] selector_nibble  = 4'hE;
  localparam logic [3:0] memory_nibble    = 4'hA;
  localparam logic [6:0] broadcast_addr   = 7'h00;
  localparam logic [7:0] crc_poly         = 8'h07;
  localparam logic [7:0] cmd_operation    = 8'h01;
  localparam logic [7:0] cmd_clear_faults = 8'h03;
  localparam logic [7:0] cmd_vout_set     = 8'h21;
  localparam logic [7:0] cmd_ov_limit     = 8'h40;
  localparam logic [7:0] cmd_read_status  = 8'hD0;
  localparam logic [7:0] cmd_mfr_first    = 8'hD2;
  localparam logic [7:0] cmd_mfr_last     = 8'hE2;
  localparam logic [7:0] cmd_led_test_on  = 8'hD2;
  localparam logic [7:0] cmd_led_test_off = 8'hD3;
  localparam logic [7:0] cmd_svc_led_on   = 8'hD4;
  localparam logic [7:0] cmd_svc_led_off  = 8'hD5;
  localparam logic [7:0] cmd_write_en     = 8'hD6;
  localparam logic [7:0] cmd_write_dis    = 8'hD7;
  localparam logic [7:0] cmd_inhibit_rst  = 8'hD8;
  localparam logic [7:0] cmd_auto_rst     = 8'hD9;
  localparam logic [7:0] cmd_iso_test     = 8'hDA;
  localparam logic [7:0] cmd_fan_set      = 8'hDF;
  localparam logic [7:0] cmd_fan_normal   = 8'hE0;
  localparam logic [7:0] cmd_clock_hold   = 8'hE2;
  localparam logic [7:0] op_on            = 8'h80;
  localparam logic [7:0] op_off           = 8'h00;
  localparam logic [3:0] status_len       = 4'hA;
  localparam int         vout_m           = 400;
  localparam int         iout_m           = 5;
  localparam int         vin_m            = 1;
  localparam int         vin_b            = 75;
  localparam int         rpm_m            = 100;
  localparam logic [15:0] vout_reset      = 16'h0000;
  // status-2 bit positions
  localparam int st2_pec_err  = 7;
  localparam int st2_invalid  = 5;
  localparam int st2_iso_fail = 3;
  localparam int st2_rst_ok   = 2;
  localparam int st2_enable   = 0;
  // status-1 bit positions
  localparam int st1_iso_ok   = 6;
  localparam int st1_shutdown = 4;
  localparam int st1_svc_led  = 3;
  localparam int st1_leds     = 1;
  localparam int st1_out_on   = 0;
  typedef enum logic [2:0] {st_idle, st_cmd, st_data, st_read, st_skip} frame_state_t;
endpackage

// [hdl/pec_crc8.sv]
// Purpose: running packet error byte over frame bytes
// Assumes: one byte per strobe
// Notes:   cleared at each frame start
`timescale 1ns/1ps
`default_nettype none
module pec_crc8 (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       byte_stb,
  input  wire logic [7:0] byte_in,
  output logic      [7:0] crc
);
  import cmd_slave_pkg::*;
  logic [7:0] next_crc;
  always_comb begin
    next_crc = crc ^ byte_in;
    for (int i = 0; i < 8; i++) begin
      next_crc = next_crc[7] ? ((next_crc << 1) ^ crc_poly) : (next_crc << 1);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= 8'h00;
    end else if (clear) begin
      crc <= 8'h00;
    end else if (byte_stb) begin
      crc <= next_crc;
    end
  end
endmodule
`default_nettype wire

// [hdl/pin_sync3.sv]
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs asynchronous to mclk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int width = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [width-1:0] pin_in,
  output logic      [width-1:0] level
);
  logic [width-1:0] s1;
  logic [width-1:0] s2;
  logic [width-1:0] s3;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  for (genvar i = 0; i < width; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        level[i] <= 1'b0;
      end else if (s2[i] == s3[i]) begin
        level[i] <= s3[i];
      end
    end
  end
endmodule
`default_nettype wire

// [test/cmd_slave_properties.sv]
// Purpose: port checks for cmd_slave
// Assumes: straps steady while frames run
// Notes:   bound to cmd_slave
`timescale 1ns/1ps
`default_nettype none
module cmd_slave_checker
  import cmd_slave_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        frame_start,
  input wire logic        frame_stop,
  input wire logic        byte_stb,
  input wire logic [7:0]  byte_in,
  input wire logic        ack,
  input wire logic        selector_ack,
  input wire logic        memory_ack,
  input wire logic        address_strap_bit_2,
  input wire logic        address_strap_bit_1,
  input wire logic        address_strap_bit_0,
  input wire logic        alert_n,
  input wire logic        output_on,
  input wire logic [15:0] vout_code,
  input wire logic        led_test,
  input wire logic        iso_test_req
);
  logic       first;
  logic [2:0] strap;
  assign strap = {address_strap_bit_2, address_strap_bit_1, address_strap_bit_0};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // -----
  // address byte, alert and execution timing
  // -----
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      first <= 1'h0;
    else if (frame_start)
      first <= 1'h1;
    else if (byte_stb)
      first <= 1'h0;
  end
  bcast_write_a: assert property (first && byte_stb && byte_in == 8'h00 |-> ack)
    else $error("bcast write nak");
  bcast_read_a: assert property (first && byte_stb && byte_in == 8'h01 |-> !ack)
    else $error("bcast read ack");
  bcast_selector_a: assert property (
    byte_stb && byte_in[7:1] == 7'h00 |-> !selector_ack && !memory_ack)
    else $error("selector bcast");
  own_addr_a: assert property (
    first && byte_stb && byte_in[7:1] == {ctrl_nibble, strap} |-> ack)
    else $error("own addr nak");
  wrong_addr_a: assert property (
    first && byte_stb && byte_in[7:4] == ctrl_nibble && byte_in[3:1] != strap |-> !ack)
    else $error("foreign ack");
  selector_match_a: assert property (
    first && byte_stb && byte_in[7:1] == {selector_nibble, strap} |-> selector_ack)
    else $error("selector nak");
  alert_first_a: assert property ($fell(output_on) |-> ##[0:4] !alert_n)
    else $error("no alert");
  exec_stop_a: assert property (
    $changed(vout_code) || $changed(led_test) || $rose(iso_test_req) |-> $past(frame_stop))
    else $error("early act");
endmodule
bind cmd_slave cmd_slave_checker chk (.*);
`default_nettype wire

// [test/host_model.sv]
// Purpose: byte-level host for cmd_slave
// Assumes: byte strobes from a front end
// Notes:   host waits shortened
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  input  wire logic       ack,
  input  wire logic [7:0] read_byte,
  output logic            frame_start,
  output logic            frame_stop,
  output logic            byte_stb,
  output logic [7:0]      byte_in,
  output logic            read_req
);
  logic [7:0] crc;
  logic       acked;
  logic [7:0] q[$];
  initial {frame_start, frame_stop, byte_stb, read_req, byte_in} = '0;
  task automatic tick;
    @(posedge mclk);
    #2;
  endtask
  task automatic put(input logic [7:0] b);
    tick;
    byte_in = b;
    byte_stb = 1'h1;
    crc = crc ^ b;
    repeat (8) crc = {crc[6:0], 1'h0} ^ (crc[7] ? 8'h07 : 8'h00);
    @(negedge mclk);
    acked = ack;
    tick;
    byte_stb = 1'h0;
    byte_in = ~b;
  endtask
  task automatic edge_pulse(input bit stop);
    tick;
    {frame_stop, frame_start} = stop ? 2'h2 : 2'h1;
    crc = 8'h00;
    tick;
    {frame_stop, frame_start} = 2'h0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input int n,
                    input logic [15:0] d, input int pec, output logic a_ack);
    edge_pulse(0);
    put({a, 1'h0});
    a_ack = acked;
    put(c);
    if (n > 0) put(d[7:0]);
    if (n > 1) put(d[15:8]);
    if (pec > 0) put(crc ^ (pec == 2 ? 8'hFF : 8'h00));
    edge_pulse(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, input int n,
                    output logic a_ack);
    edge_pulse(0);
    put({a, 1'h0});
    put(c);
    edge_pulse(0);
    put({a, 1'h1});
    a_ack = acked;
    q.delete();
    repeat (n) begin
      tick;
      read_req = 1'h1;
      tick;
      read_req = 1'h0;
      q.push_back(read_byte);
    end
    edge_pulse(1);
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// Purpose: cmd_slave bench
// Assumes: host model frames
// Notes:   long waits shortened
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cmd_slave_pkg::*;
  typedef struct {logic [6:0] a; logic [7:0] c; int n; logic [15:0] d; int s; logic [15:0] e;} row_t;
  localparam logic [2:0] strap = 3'h5;
  localparam logic [6:0] own = {ctrl_nibble, strap};
  logic        mclk, rst_n, frame_start, frame_stop, byte_stb, read_req, ack, aa;
  logic        selector_ack, memory_ack, alert_n, output_on, led_test, service_led;
  logic        mem_write_en, auto_restart, iso_test_req, fan_override, enable_pin_n;
  logic [7:0]  byte_in, read_byte, alarm_in, iout_real, temp_real, vin_real, rpm_real;
  logic [15:0] vout_code, ov_limit_code;
  int          mismatches = 0;
  int          checked = 0;
  row_t rows[14] = '{'{7'h00, 8'h21, 2, 16'h4ED4, 0, 16'h4ED4},
    '{own, 8'h40, 2, 16'h5DC0, 1, 16'h5DC0}, '{own, 8'h01, 1, 16'h0000, 2, 16'h0000},
    '{own, 8'h01, 1, 16'h0080, 2, 16'h0001}, '{own, 8'hD2, 0, 16'h0, 3, 16'h1},
    '{own, 8'hD3, 0, 16'h0, 3, 16'h0}, '{own, 8'hD4, 0, 16'h0, 4, 16'h1},
    '{own, 8'hD5, 0, 16'h0, 4, 16'h0}, '{own, 8'hD6, 0, 16'h0, 5, 16'h1},
    '{own, 8'hD7, 0, 16'h0, 5, 16'h0}, '{own, 8'hD8, 0, 16'h0, 6, 16'h0},
    '{own, 8'hD9, 0, 16'h0, 6, 16'h1}, '{own, 8'hDA, 0, 16'h0, 3, 16'h0},
    '{own, 8'hE0, 0, 16'h0, 7, 16'h0}};
  wire logic [7:0] lv = {fan_override, auto_restart, mem_write_en, service_led, led_test,
                         output_on, 2'h0};
  host_model host (.*);
  cmd_slave dut (
    .mclk, .rst_n, .frame_start, .frame_stop, .byte_stb, .byte_in, .read_req, .ack,
    .selector_ack, .memory_ack, .read_byte, .address_strap_bit_2(strap[2]),
    .address_strap_bit_1(strap[1]), .address_strap_bit_0(strap[0]), .enable_pin_n,
    .alarm_in, .iout_real, .temp_real, .vin_real, .rpm_real, .alert_n, .output_on,
    .vout_code, .ov_limit_code, .led_test, .service_led, .mem_write_en, .auto_restart,
    .iso_test_req, .fan_override, .fan_percent(), .forced_clock_hold_test()
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %0h got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt;
    repeat (4) @(posedge mclk);
    #2;
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #200000;
    mismatches++;
    final_report;
  end
  initial begin
    {rst_n, enable_pin_n, alarm_in} = '0;
    {iout_real, temp_real, vin_real, rpm_real} = 32'h0C28_9132;
    repeat (2) @(posedge mclk);
    #2 rst_n = 1'h1;
    repeat (8) @(posedge mclk);
    chk({15'h0, output_on}, 16'h1);
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].c, rows[i].n, rows[i].d, 1, aa);
      wt;
      chk({15'h0, aa}, 16'h1);
      chk(rows[i].s == 0 ? vout_code : rows[i].s == 1 ? ov_limit_code : {15'h0, lv[rows[i].s]}, rows[i].e);
      $display("row %0d done", i);
    end
    host.wr(own, 8'h01, 1, 16'h0, 2, aa);
    host.wr(own, 8'h01, 1, 16'h0, 0, aa);
    host.wr({ctrl_nibble, ~strap}, 8'h01, 1, 16'h0, 1, aa);
    chk({15'h0, aa}, 16'h0);
    host.wr({selector_nibble, strap}, 8'h00, 0, 16'h0, 0, aa);
    wt;
    chk({15'h0, output_on}, 16'h1);
    host.rd(own, 8'hD0, 12, aa);
    wt;
    chk({8'h0, host.q[0]}, 16'h000A);
    chk({15'h0, host.q[1][7]}, 16'h1);
    chk({host.q[6], host.q[5]}, 16'h4ED4);
    chk({host.q[8], host.q[7]}, 16'h003C);
    chk({15'h0, alert_n}, 16'h1);
    $display("pec done");
    host.wr(own, 8'h55, 0, 16'h0, 1, aa);
    wt;
    chk({15'h0, alert_n}, 16'h0);
    host.rd(own, 8'hD0, 12, aa);
    chk({15'h0, host.q[1][5]}, 16'h1);
    alarm_in = 8'h04;
    wt;
    alarm_in = 8'h00;
    host.wr(own, 8'h01, 1, 16'h0000, 1, aa);
    wt;
    host.wr(own, 8'h01, 1, 16'h0080, 1, aa);
    host.rd(own, 8'hD0, 12, aa);
    chk({8'h0, host.q[3]}, 16'h0);
    chk({15'h0, host.q[1][2]}, 16'h1);
    host.wr(own, 8'h03, 0, 16'h0, 1, aa);
    host.rd(own, 8'hD0, 12, aa);
    chk({14'h0, host.q[1][5], host.q[1][2]}, 16'h0);
    $display("fault done");
    host.rd(own, 8'hDC, 3, aa);
    chk({host.q[1], host.q[0]}, 16'h00DC);
    host.rd(own, 8'hE1, 6, aa);
    chk({host.q[3], host.q[2]}, 16'h1388);
    host.rd(7'h00, 8'hD0, 0, aa);
    chk({15'h0, aa}, 16'h0);
    rst_n = 1'h0;
    #5;
    chk(vout_code, 16'h0);
    chk({15'h0, alert_n}, 16'h1);
    wt;
    rst_n = 1'h1;
    wt;
    $display("reset done");
    final_report;
  end
endmodule
`default_nettype wire
